/* hw/nvcl_consts.vh */
// Constants of the nonvolatile column-latch programmer.
`ifndef NVCL_CONSTS_VH
`define NVCL_CONSTS_VH
`define NVCL_SFR_DATA_CTRL   8'hD2
`define NVCL_SFR_CODE_CTRL   8'hD1
`define NVCL_SFR_AUX_ONE     8'hA2
`define NVCL_KEY_FIRST       4'h5
`define NVCL_KEY_SECOND      4'hA
`define NVCL_BIT_MAP         1
`define NVCL_BIT_BUSY        0
`define NVCL_BIT_LATCH_MAP   3
`define NVCL_BIT_BOOT_MAP    5
`define NVCL_MODE_USER       2'b00
`define NVCL_MODE_EXTRA_ROW       2'b01
`define NVCL_MODE_SECURITY   2'b10
`define NVCL_EE_TOP          16'h07FF
`define NVCL_FL_TOP          16'h3FFF
`define NVCL_EXTRA_ROW_BASE       16'hFF80
`define NVCL_BOOT_BASE       16'hF800
`define NVCL_PAGE_BYTES      128
`define NVCL_CLK_MHZ         40
`define NVCL_PROG_US         8
`define NVCL_PROG_CYCLES     (`NVCL_PROG_US * `NVCL_CLK_MHZ)
`define NVCL_ERASE_US        4
`define NVCL_ERASE_CYCLES    (`NVCL_ERASE_US * `NVCL_CLK_MHZ)
`define NVCL_SEC_RESET       8'hFF
`endif

/* hw/nvcl_key_seq.v */
// Two-write launch key detector for one control register.
`timescale 1ns/100ps
`default_nettype none
`include "nvcl_consts.vh"
module nvcl_key_seq (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       instr_done,
  input  wire       ctrl_wr,
  input  wire [3:0] key_nib,
  input  wire       busy,
  output reg        launch
);
  reg armed_q;
  // (RQ6) abort on intervening instruction
  // Arming lasts only until the next instruction completes; any other instruction disarms.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      armed_q <= 1'b0;
      launch  <= 1'b0;
    end else begin
      launch <= 1'b0;
      if (ctrl_wr) begin
        armed_q <= (key_nib == `NVCL_KEY_FIRST);
        // (RQ24) ignore while busy
        if (armed_q && key_nib == `NVCL_KEY_SECOND && !busy)
          launch <= 1'b1;
      end else if (instr_done) begin
        armed_q <= 1'b0;
      end
    end
  end
endmodule // nvcl_key_seq
`default_nettype wire

/* hw/nvcl_prog_timer.v */
// Programming sequencer: optional erase phase, then program phase, with busy flag.
`timescale 1ns/100ps
`default_nettype none
`include "nvcl_consts.vh"
module nvcl_prog_timer (
  input  wire clk,
  input  wire sys_rst,
  input  wire start,
  input  wire with_erase,
  output reg  busy,
  output reg  erasing,
  output reg  done
);
  localparam integer ERASE_I = `NVCL_ERASE_CYCLES;
  localparam integer PROG_I  = `NVCL_PROG_CYCLES;
  localparam [15:0]  ERASE_N = ERASE_I[15:0];
  localparam [15:0]  PROG_N  = PROG_I[15:0];
  reg [15:0] cnt_q;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy    <= 1'b0;
      erasing <= 1'b0;
      done    <= 1'b0;
      cnt_q   <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (!busy) begin
        if (start) begin
          busy    <= 1'b1;
          erasing <= with_erase;
          cnt_q   <= with_erase ? ERASE_N - 16'h0001 : PROG_N - 16'h0001;
        end
      end else if (cnt_q != 16'h0000) begin
        cnt_q <= cnt_q - 16'h0001;
      end else if (erasing) begin
        erasing <= 1'b0;
        cnt_q   <= PROG_N - 16'h0001;
      end else begin
        busy <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule // nvcl_prog_timer
`default_nettype wire

/* hw/nvcl_programmer.v */
// Nonvolatile memory column-latch programmer: data EEPROM, user code flash, boot map.
`timescale 1ns/100ps
`default_nettype none
`include "nvcl_consts.vh"
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// (RQ1) Data EEPROM is 2 KB at external-data 0000h-07FFh when data_space_map set.
// (RQ2) Each EEPROM latch byte has a written marker; only marked bytes commit, then clear.
// (RQ3) EEPROM latch address: 11 bits, upper 4 row, lower 7 byte.
// (RQ4) Latest load page address wins; earlier page addresses are discarded.
// (RQ5) EEPROM launch is 50h then A0h written to data_nvm_control.
// (RQ6) Key writes must be back to back; any other instruction aborts.
// (RQ7) EEPROM busy set on launch, blocks reads, cleared by hardware only.
// (RQ8) Map bit set targets EEPROM or its latches; clear targets expanded RAM.
// (RQ9) Latch map set: writes 0000h-3FFFh load flash latches; bits 13:7 page.
// (RQ10) Flash latch map takes priority over EEPROM map for writes.
// (RQ11) Space select 00 user, 01 extra row, 10 security byte, 11 reserved.
// (RQ12) Flash key 5x then Ax; first alone does nothing, second starts.
// (RQ13) Completed key writes user, extra row or fuses per select; 11 nothing.
// (RQ14) Flash busy held for the whole programming operation.
// (RQ15) Flash launch erases loaded locations only, then programs them.
// (RQ16) Flash latches accept 1 to 128 bytes per operation.
// (RQ17) User array 128 pages of 128 bytes; extra row and latches 128 bytes.
// (RQ18) Boot map set places boot flash at F800h-FFFFh.
// (RQ19) Boot map bit loads the inverse of boot_jump_fuse at reset.
// (RQ20) User-array code may load but not program; boot code may program.
// (RQ21) Security byte upper nibble software writable, lower nibble read-only.
// (RQ22) Software disables interrupts around loading and launching.
// (RQ23) Flash busy cleared by hardware at finish, not writable by software.
// (RQ24) A key completed while that memory is busy is ignored.
module nvcl_programmer (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        instr_done,
  input  wire        sfr_wr,
  input  wire [7:0]  sfr_addr,
  input  wire [7:0]  sfr_wdata,
  output reg  [7:0]  sfr_rdata,
  input  wire        xd_wr,
  input  wire        xd_rd,
  input  wire [15:0] xd_addr,
  input  wire [7:0]  xd_wdata,
  output reg  [7:0]  xd_rdata,
  output reg         xd_ram_sel,
  input  wire        code_rd,
  input  wire [15:0] code_addr,
  input  wire        exec_from_boot,
  input  wire        boot_jump_fuse,
  output reg  [7:0]  code_rdata,
  output reg         code_boot_sel
);
  localparam integer NB = `NVCL_PAGE_BYTES;

  function in_range;
    input [15:0] a;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers.
  reg        data_space_map_q;
  reg        latch_space_map_q;
  reg  [1:0] code_space_select_q;
  reg        boot_space_map_q;
  reg        boot_loaded_q;
  wire       data_prog_busy;
  wire       code_prog_busy;
  wire       ee_done;
  wire       fl_done;
  wire       ee_launch;
  wire       fl_launch;
  wire       wr_data_ctrl = sfr_wr && (sfr_addr == `NVCL_SFR_DATA_CTRL);
  wire       wr_code_ctrl = sfr_wr && (sfr_addr == `NVCL_SFR_CODE_CTRL);
  wire       wr_aux       = sfr_wr && (sfr_addr == `NVCL_SFR_AUX_ONE);

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_space_map_q    <= 1'b0;
      latch_space_map_q   <= 1'b0;
      code_space_select_q <= 2'b00;
      boot_space_map_q    <= 1'b0;
      boot_loaded_q       <= 1'b0;
    end else begin
      // (RQ19) boot map from fuse
      if (!boot_loaded_q) begin
        boot_space_map_q <= ~boot_jump_fuse;
        boot_loaded_q    <= 1'b1;
      end else if (wr_aux) begin
        boot_space_map_q <= sfr_wdata[`NVCL_BIT_BOOT_MAP];
      end
      if (wr_data_ctrl)
        data_space_map_q <= sfr_wdata[`NVCL_BIT_MAP];
      if (wr_code_ctrl) begin
        latch_space_map_q   <= sfr_wdata[`NVCL_BIT_LATCH_MAP];
        code_space_select_q <= sfr_wdata[2:1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Launch keys and sequencers.
  // (RQ5) data key detector
  nvcl_key_seq u_ee_key (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .instr_done (instr_done),
    .ctrl_wr    (wr_data_ctrl),
    .key_nib    (sfr_wdata[7:4]),
    .busy       (data_prog_busy),
    .launch     (ee_launch)
  );
  // (RQ12) code key detector
  nvcl_key_seq u_fl_key (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .instr_done (instr_done),
    .ctrl_wr    (wr_code_ctrl),
    .key_nib    (sfr_wdata[7:4]),
    .busy       (code_prog_busy),
    .launch     (fl_launch)
  );
  // (RQ20) program only from boot, (RQ13) reserved select does nothing
  wire fl_start = fl_launch && exec_from_boot && (code_space_select_q != 2'b11);
  reg  [1:0] fl_mode_q;

  // (RQ7) data busy sequencer
  nvcl_prog_timer u_ee_tmr (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .start      (ee_launch),
    .with_erase (1'b0),
    .busy       (data_prog_busy),
    .erasing    (),
    .done       (ee_done)
  );
  // (RQ15) erase then program, (RQ14) busy throughout
  // (RQ23) busy cleared by hardware only
  nvcl_prog_timer u_fl_tmr (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .start      (fl_start),
    .with_erase (1'b1),
    .busy       (code_prog_busy),
    .erasing    (),
    .done       (fl_done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Arrays and column latches.
  reg [7:0]  ee_mem   [0:2047];
  reg [7:0]  ee_lat   [0:NB-1];
  reg [NB-1:0] ee_mark_q;
  reg [3:0]  ee_row_q;
  reg [7:0]  fl_mem   [0:16383];
  reg [7:0]  extra_row_mem [0:NB-1];
  reg [7:0]  fl_lat   [0:NB-1];
  reg [NB-1:0] fl_mark_q;
  reg [7:0]  fl_page_q;
  reg [7:0]  sec_q;

  // (RQ10) latch map wins over EEPROM map
  wire fl_load = xd_wr && latch_space_map_q && in_range(xd_addr, 16'h0000, `NVCL_FL_TOP);
  // (RQ8) EEPROM latch load when mapped
  wire ee_load = xd_wr && !latch_space_map_q && data_space_map_q &&
                 in_range(xd_addr, 16'h0000, `NVCL_EE_TOP) && !data_prog_busy;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ee_mark_q <= {NB{1'b0}};
      ee_row_q  <= 4'h0;
      fl_mark_q <= {NB{1'b0}};
      fl_page_q <= 8'h00;
      fl_mode_q <= `NVCL_MODE_USER;
      sec_q     <= `NVCL_SEC_RESET;
    end else begin
      // (RQ2) clear markers after row; a load in the same cycle still sets its marker.
      if (ee_done)
        ee_mark_q <= {NB{1'b0}};
      if (ee_load) begin
        // (RQ3) 4-bit row, 7-bit byte; (RQ4) latest row wins
        ee_row_q <= xd_addr[10:7];
        // (RQ2) set written marker
        ee_mark_q[xd_addr[6:0]] <= 1'b1;
      end
      if (fl_done)
        fl_mark_q <= {NB{1'b0}};
      if (fl_load) begin
        // (RQ9) page from bits 13:7
        fl_page_q <= {1'b0, xd_addr[13:7]};
        // (RQ16) any byte count
        fl_mark_q[xd_addr[6:0]] <= 1'b1;
      end
      if (fl_start)
        fl_mode_q <= code_space_select_q;
      // (RQ21) only upper nibble of security byte
      if (fl_done && fl_mode_q == `NVCL_MODE_SECURITY && fl_mark_q[0])
        sec_q <= {fl_lat[0][7:4], sec_q[3:0]};
    end
  end

  genvar g;
  generate
    for (g = 0; g < NB; g = g + 1) begin : g_col
      localparam [6:0] COL = g;
      always @(posedge clk) begin
        if (ee_load && xd_addr[6:0] == COL)
          ee_lat[g] <= xd_wdata;
        if (fl_load && xd_addr[6:0] == COL)
          fl_lat[g] <= xd_wdata;
        // (RQ2) commit marked EEPROM bytes only
        if (ee_done && ee_mark_q[g])
          ee_mem[{ee_row_q, COL}] <= ee_lat[g];
        // (RQ17) 128-byte pages; (RQ13) target per select
        if (fl_done && fl_mark_q[g] && fl_mode_q == `NVCL_MODE_USER)
          fl_mem[{fl_page_q[6:0], COL}] <= fl_lat[g];
        if (fl_done && fl_mark_q[g] && fl_mode_q == `NVCL_MODE_EXTRA_ROW)
          extra_row_mem[g] <= fl_lat[g];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Read paths, all registered.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sfr_rdata     <= 8'h00;
      xd_rdata      <= 8'h00;
      xd_ram_sel    <= 1'b1;
      code_rdata    <= 8'hFF;
      code_boot_sel <= 1'b0;
    end else begin
      case (sfr_addr)
        `NVCL_SFR_DATA_CTRL: sfr_rdata <= {6'h00, data_space_map_q, data_prog_busy};
        `NVCL_SFR_CODE_CTRL: sfr_rdata <= {4'h0, latch_space_map_q, code_space_select_q, code_prog_busy};
        `NVCL_SFR_AUX_ONE:   sfr_rdata <= {2'b00, boot_space_map_q, 5'h00};
        default:             sfr_rdata <= 8'h00;
      endcase
      // (RQ1) EEPROM window; (RQ8) RAM otherwise
      xd_ram_sel <= !(data_space_map_q && !latch_space_map_q) || !in_range(xd_addr, 16'h0000, `NVCL_EE_TOP);
      if (xd_rd && data_space_map_q && !latch_space_map_q && in_range(xd_addr, 16'h0000, `NVCL_EE_TOP))
        // (RQ7) reads blocked while busy
        xd_rdata <= data_prog_busy ? 8'hFF : ee_mem[xd_addr[10:0]];
      // (RQ18) boot window
      code_boot_sel <= boot_space_map_q && in_range(code_addr, `NVCL_BOOT_BASE, 16'hFFFF);
      if (code_rd) begin
        // (RQ11) space select
        case (code_space_select_q)
          `NVCL_MODE_USER:     code_rdata <= fl_mem[code_addr[13:0]];
          `NVCL_MODE_EXTRA_ROW:     code_rdata <= extra_row_mem[code_addr[6:0]];
          `NVCL_MODE_SECURITY: code_rdata <= sec_q;
          default:             code_rdata <= 8'hFF;
        endcase
      end
    end
  end
endmodule // nvcl_programmer
`default_nettype wire

/* test/nvcl_checker.sv */
// Port-level assertions for the column-latch programmer.
`timescale 1ns/100ps
`default_nettype none
module nvcl_checker (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        instr_done,
  input wire logic        sfr_wr,
  input wire logic [7:0]  sfr_addr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        xd_rd,
  input wire logic [7:0]  xd_rdata,
  input wire logic        xd_ram_sel,
  input wire logic        code_rd,
  input wire logic [15:0] code_addr,
  input wire logic        exec_from_boot,
  input wire logic [7:0]  code_rdata,
  input wire logic        code_boot_sel
);
  localparam logic [7:0] DA = 8'hD2;
  localparam logic [7:0] CA = 8'hD1;
  logic [7:0] aq_q;
  logic [9:0] run_q;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Counts busy cycles seen on one control register without a change of address.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aq_q  <= 8'h00;
      run_q <= 10'h000;
    end else begin
      aq_q  <= sfr_addr;
      run_q <= (sfr_rdata[0] && aq_q == sfr_addr) ? run_q + 10'h001 : 10'h000;
    end
  end
  launch_busy_a:
    assert property (sfr_wr && sfr_addr == DA && sfr_wdata[7:4] == 4'h5 ##1 sfr_wr && sfr_addr == DA
      && sfr_wdata[7:4] == 4'hA && !instr_done |-> ##[3:4] sfr_rdata[0]) else $error("data busy not raised");
  abort_key_a:
    assert property ($past(sfr_addr) == DA && !sfr_rdata[0] && sfr_wr && sfr_addr == DA && sfr_wdata[7:4] == 4'h5
      ##1 instr_done ##1 sfr_wr && sfr_addr == DA && sfr_wdata[7:4] == 4'hA |-> ##1 !sfr_rdata[0] [*6])
      else $error("aborted key launched");
  read_block_a:
    assert property (xd_rd && sfr_addr == DA ##1 sfr_rdata[1:0] == 2'b11 |-> xd_rdata == 8'hFF)
      else $error("read not blocked while busy");
  busy_len_a:
    assert property (run_q <= (aq_q == CA ? 10'h1E2 : 10'h142)) else $error("busy held too long");
  ram_sel_a:
    assert property (xd_rd && sfr_addr == DA ##1 !sfr_rdata[1] |-> xd_ram_sel) else $error("read not sent to ram");
  code_guard_a:
    assert property ($past(sfr_addr) == CA && !sfr_rdata[0] && sfr_wr && sfr_addr == CA && sfr_wdata[7:4] == 4'h5
      ##1 sfr_wr && sfr_addr == CA && sfr_wdata[7:4] == 4'hA && (!exec_from_boot || sfr_wdata[2:1] == 2'b11)
      |-> ##1 !sfr_rdata[0] [*6]) else $error("refused flash key launched");
  boot_sel_a:
    assert property (code_rd ##1 code_boot_sel |-> $past(code_addr) >= 16'hF800) else $error("boot select low addr");
  sec_low_a:
    assert property (code_rd && code_addr == 16'h0000 && sfr_addr == CA ##1 sfr_rdata[2:0] == 3'b100
      |-> code_rdata[3:0] == 4'hF) else $error("security low nibble changed");
endmodule // nvcl_checker
bind nvcl_programmer nvcl_checker u_chk (.clk, .sys_rst, .instr_done, .sfr_wr, .sfr_addr, .sfr_wdata,
  .sfr_rdata, .xd_rd, .xd_rdata, .xd_ram_sel, .code_rd, .code_addr, .exec_from_boot, .code_rdata, .code_boot_sel);
`default_nettype wire

/* test/nvcl_cpu_model.sv */
// Behavioural CPU core issuing register, external-data and code accesses.
`timescale 1ns/100ps
`default_nettype none
module nvcl_cpu_model (
  input  wire logic        clk,
  output var  logic        instr_done = 1'b0,
  output var  logic        sfr_wr = 1'b0,
  output var  logic [7:0]  sfr_addr = 8'h00,
  output var  logic [7:0]  sfr_wdata = 8'h00,
  output var  logic        xd_wr = 1'b0,
  output var  logic        xd_rd = 1'b0,
  output var  logic [15:0] xd_addr = 16'h0000,
  output var  logic [7:0]  xd_wdata = 8'h00,
  output var  logic        code_rd = 1'b0,
  output var  logic [15:0] code_addr = 16'h0000
);
  // One instruction per call: 0 sfr write, 1 xd write, 2 xd read, 3 code read, 4 other, 5 idle, 6 sfr select.
  // back-to-back keys, no interrupts
  task automatic op(input int k, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    instr_done <= k == 4;
    sfr_wr     <= k == 0;
    xd_wr      <= k == 1;
    xd_rd      <= k == 2;
    code_rd    <= k == 3;
    sfr_addr   <= (k == 0 || k == 6) ? a[7:0] : sfr_addr;
    sfr_wdata  <= k == 0 ? d : ~sfr_wdata;
    xd_addr    <= (k == 1 || k == 2) ? a : ~xd_addr;
    xd_wdata   <= k == 1 ? d : ~xd_wdata;
    code_addr  <= k == 3 ? a : ~code_addr;
  endtask
endmodule // nvcl_cpu_model
`default_nettype wire

/* test/nvcl_programmer_bench.sv */
// Self-checking bench for the column-latch programmer.
`timescale 1ns/100ps
`default_nettype none
module nvcl_programmer_bench;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        exec_from_boot = 1'b1;
  logic        boot_jump_fuse = 1'b0;
  logic        instr_done, sfr_wr, xd_wr, xd_rd, code_rd, xd_ram_sel, code_boot_sel;
  logic [7:0]  sfr_addr, sfr_wdata, xd_wdata, sfr_rdata, xd_rdata, code_rdata;
  logic [15:0] xd_addr, code_addr;
  logic [7:0]  v [4];
  logic [6:0]  ix [4];
  int          n_mismatch = 0;
  int          total_checks = 0;
  always #12.5 clk = ~clk;
  nvcl_programmer u_dut (.clk, .sys_rst, .instr_done, .sfr_wr, .sfr_addr, .sfr_wdata, .sfr_rdata, .xd_wr, .xd_rd,
    .xd_addr, .xd_wdata, .xd_rdata, .xd_ram_sel, .code_rd, .code_addr, .exec_from_boot, .boot_jump_fuse,
    .code_rdata, .code_boot_sel);
  nvcl_cpu_model u_cpu (.clk, .instr_done, .sfr_wr, .sfr_addr, .sfr_wdata, .xd_wr, .xd_rd, .xd_addr, .xd_wdata,
    .code_rd, .code_addr);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (n_mismatch == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cpu(input int k, input logic [15:0] a, input logic [7:0] d);
    u_cpu.op(k, a, d);
  endtask
  task automatic rd(input int k, input logic [15:0] a, output logic [7:0] q);
    cpu(k, a, 8'h00);
    cpu(5, 16'h0000, 8'h00);
    #1;
    q = k == 3 ? code_rdata : k == 2 ? xd_rdata : sfr_rdata;
  endtask
  // Waits for the busy bit of one control register to reach a level; returns the cycle number.
  task automatic wt(input logic [7:0] a, input logic b, input int lim, output int t);
    cpu(6, {8'h00, a}, 8'h00);
    for (int c = 0; c <= lim; c++) begin
      @(posedge clk);
      #1;
      t = int'($time / 25);
      if (sfr_rdata[0] === b) return;
    end
    n_mismatch++;
    finish_test();
  endtask
  // Launches, repeats the key while busy, and checks the busy length.
  task automatic launch(input logic [7:0] a, input logic [7:0] lo, input int len);
    int t0;
    int t1;
    logic [7:0] s;
    cpu(0, {8'h00, a}, 8'h50 | lo);
    cpu(0, {8'h00, a}, 8'hA0 | lo);
    wt(a, 1'b1, 8, t0);
    rd(2, 16'h0000, s);
    if (a == 8'hD2) chk(s, 8'hFF);
    cpu(0, {8'h00, a}, 8'h50 | lo);
    cpu(0, {8'h00, a}, 8'hA0 | lo);
    wt(a, 1'b0, 700, t1);
    chk({7'h00, t1 - t0 >= len - 2 && t1 - t0 <= len + 2}, 8'h01);
  endtask
  initial begin
    logic [7:0] s;
    logic [3:0] r;
    logic [6:0] p;
    void'($urandom(32'h8E8E18E4));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(6, 16'h00A2, s);
    chk(s & 8'h20, 8'h20);
    rd(3, 16'hF800 | 16'($urandom_range(2047)), s);
    chk({7'h00, code_boot_sel}, 8'h01);
    rd(3, 16'h07FF, s);
    chk({7'h00, code_boot_sel}, 8'h00);
    cpu(0, 16'h00D2, 8'h00);
    rd(2, 16'h0010, s);
    chk({7'h00, xd_ram_sel}, 8'h01);
    cpu(0, 16'h00D2, 8'h02);
    rd(2, 16'h0010, s);
    chk({7'h00, xd_ram_sel}, 8'h00);
    r = 4'($urandom);
    p = 7'($urandom);
    for (int i = 0; i < 4; i++) begin
      v[i] = 8'($urandom);
      ix[i] = i == 0 ? 7'h00 : i == 1 ? 7'h7F : i == 2 ? 7'h20 + 7'(p[5:0]) : 7'h60 + 7'(p[3:0]);
      cpu(1, {5'h00, i == 3 ? r : r + 4'h1, ix[i]}, v[i]);
    end
    launch(8'hD2, 8'h02, 320);
    for (int i = 0; i < 4; i++) begin
      rd(2, {5'h00, r, ix[i]}, s);
      chk(s, v[i]);
    end
    cpu(0, 16'h00D2, 8'h52);
    cpu(4, 16'h0000, 8'h00);
    cpu(0, 16'h00D2, 8'hA2);
    cpu(6, 16'h00D2, 8'h00);
    repeat (6) @(posedge clk);
    #1;
    chk({7'h00, sfr_rdata[0]}, 8'h00);
    // A second pass reloads one byte only, so the rest of the page must survive the auto-erase.
    for (int j = 0; j < 2; j++) begin
      cpu(0, 16'h00D1, 8'h08);
      for (int i = 0; i < 4 - 3 * j; i++)
        cpu(1, {2'b00, i == 3 || j == 1 ? p : ~p, ix[i]}, j == 1 ? ~v[i] : v[i]);
      launch(8'hD1, 8'h00, 480);
    end
    v[0] = ~v[0];
    for (int i = 0; i < 4; i++) begin
      rd(3, {2'b00, p, ix[i]}, s);
      chk(s, v[i]);
    end
    cpu(0, 16'h00D1, 8'h08);
    cpu(1, {9'h000, ix[1]}, v[1]);
    launch(8'hD1, 8'h02, 480);
    cpu(0, 16'h00D1, 8'h02);
    rd(3, {9'h1FF, ix[1]}, s);
    chk(s, v[1]);
    cpu(0, 16'h00D1, 8'h08);
    cpu(1, 16'h0000, v[2]);
    launch(8'hD1, 8'h04, 480);
    cpu(0, 16'h00D1, 8'h04);
    rd(3, 16'h0000, s);
    chk(s, {v[2][7:4], 4'hF});
    for (int j = 0; j < 2; j++) begin
      @(posedge clk);
      exec_from_boot <= j == 1;
      cpu(0, 16'h00D1, 8'h50 | 8'(j * 6));
      cpu(0, 16'h00D1, 8'hA0 | 8'(j * 6));
      cpu(6, 16'h00D1, 8'h00);
      repeat (6) @(posedge clk);
      #1;
      chk({7'h00, sfr_rdata[0]}, 8'h00);
    end
    @(posedge clk);
    boot_jump_fuse <= 1'b1;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(6, 16'h00A2, s);
    chk(s & 8'h20, 8'h00);
    finish_test();
  end
endmodule // nvcl_programmer_bench
`default_nettype wire
